/* File: rtl/jil_pkg.sv */
// jil_pkg: shared constants for the test access port and instruction logic
// assumes one 25 MHz system clock that samples the slow test clock pin
package jil_pkg;

	// instruction register
	localparam int unsigned IR_LEN          = 10;
	localparam logic [9:0]  IR_CAPTURE_VAL  = 10'h001;
	localparam logic [9:0]  OP_CLAMP        = 10'h00A;
	localparam logic [9:0]  OP_USER_A       = 10'h00C;
	localparam logic [9:0]  OP_USER_B       = 10'h00E;
	localparam logic [9:0]  OP_BYPASS       = 10'h3FF;

	// 32-bit data registers and identification field layout
	localparam int unsigned DR32_LEN        = 32;
	localparam int unsigned ID_VER_LSB      = 28;
	localparam int unsigned ID_PART_LSB     = 12;
	localparam int unsigned ID_MFR_LSB      = 1;
	localparam logic        ID_FIXED_LSB    = 1'b1;

	// boundary-scan length per density, three cells per pin
	localparam int unsigned BSR_LEN [4]     = '{240, 480, 636, 816};
	localparam int unsigned CELLS_PER_PIN   = 3;

	// clock figures
	localparam int unsigned CLK_HZ          = 25_000_000;
	localparam int unsigned SYNC_STAGES     = 2;

	// sixteen-state test access port controller
	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
	} jil_tap_t;

	// data register selected by the current instruction
	typedef enum logic [2:0] {
		SEL_BYP, SEL_ID, SEL_UC, SEL_BSR, SEL_UA, SEL_UB, SEL_ISC
	} jil_sel_t;

endpackage

/* File: rtl/jil_bscan_cells.sv */
// jil_bscan_cells: boundary-scan register, three cells per pin (in, out, oe)
// assumes capture/shift/update pulses come from the tap controller on clk_i
`timescale 1ns/10ps
module jil_bscan_cells #(
	parameter int unsigned NPINS = 160
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// scan control
	input  wire logic             capture_i,
	input  wire logic             shift_i,
	input  wire logic             update_i,
	input  wire logic             tdi_i,
	output logic                  tdo_o,
	// pin mode
	input  wire logic             drive_i,
	input  wire logic             float_i,
	// core side
	input  wire logic [NPINS-1:0] core_out_i,
	input  wire logic [NPINS-1:0] core_oe_i,
	output logic      [NPINS-1:0] core_in_o,
	// pad side
	input  wire logic [NPINS-1:0] pad_i,
	output logic      [NPINS-1:0] pad_o,
	output logic      [NPINS-1:0] pad_oe_o
);
	import jil_pkg::*;

	localparam int unsigned NCELL = NPINS * CELLS_PER_PIN;

	logic [NCELL-1:0] sh_r;
	logic [NCELL-1:0] upd_r;
	logic [NPINS-1:0] pad_s1_r;
	logic [NPINS-1:0] pad_s2_r;

	assign tdo_o     = sh_r[0];
	assign core_in_o = pad_s2_r;

	////////////////////////////////////////////////////////////////////////////////
	// pad input synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pad_s1_r <= '0;
			pad_s2_r <= '0;
		end else begin
			pad_s1_r <= pad_i;
			pad_s2_r <= pad_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// per-pin cells
	genvar p;
	generate
		for (p = 0; p < NPINS; p++) begin : g_pin
			localparam int unsigned C = p * CELLS_PER_PIN;
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					sh_r[C+2:C]  <= '0;
					upd_r[C+2:C] <= '0;
					pad_o[p]     <= 1'b0;
					pad_oe_o[p]  <= 1'b0;
				end else begin
					if (capture_i) begin
						sh_r[C+2:C] <= {core_oe_i[p], core_out_i[p], pad_s2_r[p]};
					end else if (shift_i) begin
						sh_r[C+2:C] <= {((C + 3 < NCELL) ? sh_r[(C+3) % NCELL] : tdi_i), sh_r[C+2:C+1]};
					end
					if (update_i) begin
						upd_r[C+2:C] <= sh_r[C+2:C];
					end
					// pins follow the update latches while drive_i is held, except that float_i forces the enables low
					pad_o[p]    <= drive_i ? upd_r[C+1] : core_out_i[p];
					pad_oe_o[p] <= float_i ? 1'b0 : (drive_i ? upd_r[C+2] : core_oe_i[p]);
				end
			end
		end
	endgenerate

endmodule // jil_bscan_cells

/* File: rtl/jil_tap_top.sv */
// jil_tap_top: test access port, 10-bit instruction register and its data registers
// assumes test pins are asynchronous to clk_i and the test clock runs well below clk_i/4
`timescale 1ns/10ps
module jil_tap_top #(
	parameter int unsigned DENSITY     = 1,
	parameter int unsigned ISC_W       = 16,
	parameter logic [9:0]  OP_EXTEST   = 10'h00F,
	parameter logic [9:0]  OP_SAMPLE   = 10'h005,
	parameter logic [9:0]  OP_IDCODE   = 10'h006,
	parameter logic [9:0]  OP_USERCODE = 10'h007,
	parameter logic [9:0]  OP_HIGHZ    = 10'h00B,
	parameter logic [9:0]  OP_ISC_EN   = 10'h2CC,
	parameter logic [9:0]  OP_ISC_DIS  = 10'h201,
	parameter logic [9:0]  OP_ISC_PROG = 10'h2F4,
	parameter logic [9:0]  OP_ISC_READ = 10'h205,
	// identification values are arbitrary
	parameter logic [3:0]  ID_VERSION  = 4'h1,
	parameter logic [15:0] ID_PART     = 16'h5A30,
	parameter logic [10:0] ID_MFR      = 11'h2A5,
	parameter int unsigned NPINS       = jil_pkg::BSR_LEN[DENSITY] / jil_pkg::CELLS_PER_PIN
) (
	// clock and reset
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	// test pins
	input  wire logic                          tck_i,
	input  wire logic                          tms_i,
	input  wire logic                          tdi_i,
	output logic                               tdo_o,
	output logic                               tdo_oe_o,
	// user code and user chains
	input  wire logic [jil_pkg::DR32_LEN-1:0]  usercode_i,
	output logic                               user_sel_a_o,
	output logic                               user_sel_b_o,
	output logic                               user_capture_o,
	output logic                               user_shift_o,
	output logic                               user_update_o,
	output logic                               user_tdi_o,
	input  wire logic                          user_tdo_i,
	// in-system configuration
	output logic                               isc_active_o,
	output logic [jil_pkg::IR_LEN-1:0]         isc_op_o,
	output logic                               isc_wr_o,
	output logic                               isc_rd_o,
	output logic [ISC_W-1:0]                   isc_wdata_o,
	input  wire logic [ISC_W-1:0]              isc_rdata_i,
	// pins
	output logic                               pin_keep_o,
	input  wire logic [NPINS-1:0]              core_out_i,
	input  wire logic [NPINS-1:0]              core_oe_i,
	output logic      [NPINS-1:0]              core_in_o,
	input  wire logic [NPINS-1:0]              pad_i,
	output logic      [NPINS-1:0]              pad_o,
	output logic      [NPINS-1:0]              pad_oe_o
);
	import jil_pkg::*;

	jil_tap_t          tap_r;
	jil_tap_t          tap_nxt;
	jil_sel_t          sel;
	logic [2:0]        tck_s_r;
	logic [1:0]        tms_s_r;
	logic [1:0]        tdi_s_r;
	logic              tck_rise;
	logic              tck_fall;
	logic              tms_s;
	logic              tdi_s;
	logic [IR_LEN-1:0] ir_r;
	logic [IR_LEN-1:0] ir_sh_r;
	logic [31:0]       dr32_r;
	logic              byp_r;
	logic [ISC_W-1:0]  isc_sh_r;
	logic              isc_active_r;
	logic              bsr_tdo;
	logic              pin_drive;
	logic              pin_float;
	logic [31:0]       idcode;

	assign idcode = {ID_VERSION, ID_PART, ID_MFR, ID_FIXED_LSB};

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and test clock edges
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// test clock idles high between frames; a low reset value would fake a rise at release
			tck_s_r <= 3'h7;
			tms_s_r <= 2'h3;
			tdi_s_r <= '0;
		end else begin
			tck_s_r <= {tck_s_r[1:0], tck_i};
			tms_s_r <= {tms_s_r[0], tms_i};
			tdi_s_r <= {tdi_s_r[0], tdi_i};
		end
	end
	assign tck_rise = tck_s_r[1] & ~tck_s_r[2];
	assign tck_fall = ~tck_s_r[1] & tck_s_r[2];
	assign tms_s    = tms_s_r[1];
	assign tdi_s    = tdi_s_r[1];

	////////////////////////////////////////////////////////////////////////////////
	// tap state machine
	always_comb begin
		unique case (tap_r)
			TLR:    tap_nxt = tms_s ? TLR    : RTI;
			RTI:    tap_nxt = tms_s ? SEL_DR : RTI;
			SEL_DR: tap_nxt = tms_s ? SEL_IR : CAP_DR;
			CAP_DR: tap_nxt = tms_s ? EX1_DR : SH_DR;
			SH_DR:  tap_nxt = tms_s ? EX1_DR : SH_DR;
			EX1_DR: tap_nxt = tms_s ? UPD_DR : PA_DR;
			PA_DR:  tap_nxt = tms_s ? EX2_DR : PA_DR;
			EX2_DR: tap_nxt = tms_s ? UPD_DR : SH_DR;
			UPD_DR: tap_nxt = tms_s ? SEL_DR : RTI;
			SEL_IR: tap_nxt = tms_s ? TLR    : CAP_IR;
			CAP_IR: tap_nxt = tms_s ? EX1_IR : SH_IR;
			SH_IR:  tap_nxt = tms_s ? EX1_IR : SH_IR;
			EX1_IR: tap_nxt = tms_s ? UPD_IR : PA_IR;
			PA_IR:  tap_nxt = tms_s ? EX2_IR : PA_IR;
			EX2_IR: tap_nxt = tms_s ? UPD_IR : SH_IR;
			UPD_IR: tap_nxt = tms_s ? SEL_DR : RTI;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tap_r <= TLR;
		end else if (tck_rise) begin
			tap_r <= tap_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// instruction register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ir_sh_r <= IR_CAPTURE_VAL;
			ir_r    <= OP_IDCODE;
		end else begin
			if (tck_rise && tap_r == CAP_IR) begin
				ir_sh_r <= IR_CAPTURE_VAL;
			end else if (tck_rise && tap_r == SH_IR) begin
				ir_sh_r <= {tdi_s, ir_sh_r[IR_LEN-1:1]};
			end
			if (tap_r == TLR) begin
				ir_r <= OP_IDCODE;
			end else if (tck_fall && tap_r == UPD_IR) begin
				ir_r <= ir_sh_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// instruction decode
	always_comb begin
		sel = SEL_BYP;
		if (ir_r == OP_IDCODE) sel = SEL_ID;
		else if (ir_r == OP_USERCODE) sel = SEL_UC;
		else if (ir_r == OP_EXTEST || ir_r == OP_SAMPLE) sel = SEL_BSR;
		else if (ir_r == OP_USER_A) sel = SEL_UA;
		else if (ir_r == OP_USER_B) sel = SEL_UB;
		else if (ir_r == OP_ISC_PROG || ir_r == OP_ISC_READ) sel = SEL_ISC;
	end
	assign pin_drive = (ir_r == OP_EXTEST) || (ir_r == OP_CLAMP);
	assign pin_float = (ir_r == OP_HIGHZ) || isc_active_r;
	// keepers stay on in every mode
	assign pin_keep_o = 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	// data registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			byp_r    <= 1'b0;
			dr32_r   <= '0;
			isc_sh_r <= '0;
		end else if (tck_rise && tap_r == CAP_DR) begin
			byp_r <= 1'b0;
			dr32_r   <= (sel == SEL_UC) ? usercode_i : idcode;
			isc_sh_r <= isc_rdata_i;
		end else if (tck_rise && tap_r == SH_DR) begin
			byp_r    <= tdi_s;
			dr32_r   <= {tdi_s, dr32_r[31:1]};
			isc_sh_r <= {tdi_s, isc_sh_r[ISC_W-1:1]};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// in-system configuration
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			isc_active_r <= 1'b0;
			isc_wr_o     <= 1'b0;
			isc_rd_o     <= 1'b0;
			isc_wdata_o  <= '0;
		end else begin
			if (tck_fall && tap_r == UPD_IR && ir_sh_r == OP_ISC_EN) begin
				isc_active_r <= 1'b1;
			end else if (tck_fall && tap_r == UPD_IR && ir_sh_r == OP_ISC_DIS) begin
				isc_active_r <= 1'b0;
			end
			// serial data in, read-back captured for output
			isc_wr_o <= tck_fall && tap_r == UPD_DR && isc_active_r && ir_r == OP_ISC_PROG;
			isc_rd_o <= tck_rise && tap_r == CAP_DR && isc_active_r && ir_r == OP_ISC_READ;
			if (tck_fall && tap_r == UPD_DR && isc_active_r && ir_r == OP_ISC_PROG) begin
				isc_wdata_o <= isc_sh_r;
			end
		end
	end
	assign isc_active_o = isc_active_r;
	assign isc_op_o     = ir_r;

	////////////////////////////////////////////////////////////////////////////////
	// user chain routing
	assign user_sel_a_o   = (sel == SEL_UA);
	assign user_sel_b_o   = (sel == SEL_UB);
	assign user_capture_o = tck_rise && tap_r == CAP_DR && (user_sel_a_o || user_sel_b_o);
	assign user_shift_o   = tck_rise && tap_r == SH_DR && (user_sel_a_o || user_sel_b_o);
	assign user_update_o  = tck_fall && tap_r == UPD_DR && (user_sel_a_o || user_sel_b_o);
	assign user_tdi_o     = tdi_s;

	////////////////////////////////////////////////////////////////////////////////
	// test data output, changes on the falling test clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tdo_o    <= 1'b0;
			tdo_oe_o <= 1'b0;
		end else if (tck_fall) begin
			tdo_oe_o <= (tap_r == SH_DR) || (tap_r == SH_IR);
			if (tap_r == SH_IR) begin
				tdo_o <= ir_sh_r[0];
			end else if (tap_r == SH_DR) begin
				unique case (sel)
					SEL_BYP:         tdo_o <= byp_r;
					SEL_ID, SEL_UC:  tdo_o <= dr32_r[0];
					SEL_BSR:         tdo_o <= bsr_tdo;
					SEL_UA, SEL_UB:  tdo_o <= user_tdo_i;
					SEL_ISC:         tdo_o <= isc_sh_r[0];
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// boundary-scan register sized by density
	jil_bscan_cells #(
		.NPINS (NPINS)
	) u_bsr (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.capture_i  (tck_rise && tap_r == CAP_DR && sel == SEL_BSR),
		.shift_i    (tck_rise && tap_r == SH_DR && sel == SEL_BSR),
		.update_i   (tck_fall && tap_r == UPD_DR && sel == SEL_BSR),
		.tdi_i      (tdi_s),
		.tdo_o      (bsr_tdo),
		.drive_i    (pin_drive),
		.float_i    (pin_float),
		.core_out_i (core_out_i),
		.core_oe_i  (core_oe_i),
		.core_in_o  (core_in_o),
		.pad_i      (pad_i),
		.pad_o      (pad_o),
		.pad_oe_o   (pad_oe_o)
	);

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_rise_tms1;
		tck_rise && tms_s;
	endsequence

	property p_ir_shift;
		tck_rise && tap_r == SH_IR |=> ir_sh_r[IR_LEN-1] == $past(tdi_s) && ir_sh_r[8:0] == $past(ir_sh_r[9:1]);
	endproperty
	a_ir_shift: assert property (p_ir_shift) else $error("ir shift wrong");

	property p_uc_capture;
		tck_rise && tap_r == CAP_DR && sel == SEL_UC |=> dr32_r == $past(usercode_i);
	endproperty
	a_uc_capture: assert property (p_uc_capture) else $error("usercode not captured");

	property p_clamp;
		ir_r == OP_CLAMP |-> sel == SEL_BYP && pin_drive && !pin_float;
	endproperty
	a_clamp: assert property (p_clamp) else $error("clamp decode wrong");

	property p_user_shift;
		tck_rise && tap_r == SH_DR && ir_r == OP_USER_B |-> user_shift_o && user_sel_b_o && !user_sel_a_o;
	endproperty
	a_user_shift: assert property (p_user_shift) else $error("user chain b not routed");

	property p_keep;
		(ir_r == OP_HIGHZ || pin_drive) |-> pin_keep_o;
	endproperty
	a_keep: assert property (p_keep) else $error("keeper dropped");

	property p_id_capture;
		tck_rise && tap_r == CAP_DR && sel == SEL_ID |=> dr32_r[0] && dr32_r[31:28] == ID_VERSION;
	endproperty
	a_id_capture: assert property (p_id_capture) else $error("idcode layout wrong");

	property p_upd_to_sel;
		tap_r == UPD_DR ##0 s_rise_tms1 |=> tap_r == SEL_DR;
	endproperty
	a_upd_to_sel: assert property (p_upd_to_sel) else $error("tap move wrong");

	property p_tap_hold;
		!tck_rise |=> $stable(tap_r);
	endproperty
	a_tap_hold: assert property (p_tap_hold) else $error("tap moved without tck");

	property p_tlr_id;
		tap_r == TLR |=> ir_r == OP_IDCODE ##1 sel == SEL_ID;
	endproperty
	a_tlr_id: assert property (p_tlr_id) else $error("reset not idcode");

	property p_isc_out;
		tck_fall && tap_r == SH_DR && sel == SEL_ISC |=> tdo_o == $past(isc_sh_r[0]) && tdo_oe_o;
	endproperty
	a_isc_out: assert property (p_isc_out) else $error("isc readback not on tdo");

endmodule // jil_tap_top

/* File: testbench/jil_test_ctrl.sv */
// jil_test_ctrl: behavioural test controller on the far side of the tap pins
// assumes it is called at a falling edge of clk_i; pins change only there
`timescale 1ns/10ps
module jil_test_ctrl (
	// system clock
	input  wire logic clk_i,
	// test pins
	output logic      tck_o,
	output logic      tms_o,
	output logic      tdi_o,
	input  wire logic tdo_i,
	input  wire logic tdo_oe_i
);
	int unsigned oe_bad;

	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b0;
		oe_bad = 0;
	end

	////////////////////////////////////////
	// one test clock period of 8 clk, tdo taken at the end of the high phase
	task automatic tck_bit(input logic tms, input logic tdi, output logic tdo);
		tck_o = 1'b0;
		tms_o = tms;
		tdi_o = tdi;
		repeat (4) @(negedge clk_i);
		tck_o = 1'b1;
		repeat (4) @(negedge clk_i);
		tdo = tdo_i;
	endtask

	// idle data line toggles so a stale bit never reads as valid
	task automatic nav(input logic tms);
		logic d;
		tck_bit(tms, ~tdi_o, d);
	endtask

	task automatic to_reset();
		repeat (5) nav(1'b1);
		nav(1'b0);
	endtask

	////////////////////////////////////////
	// standard state walk
	task automatic scan(input logic is_ir, input int n, input logic [511:0] din, output logic [511:0] dout);
		dout = '0;
		nav(1'b1);
		if (is_ir)
			nav(1'b1);
		nav(1'b0);
		nav(1'b0);
		for (int i = 0; i < n; i++) begin
			tck_bit(i == n - 1, din[i], dout[i]);
			if (tdo_oe_i !== 1'b1)
				oe_bad++;
		end
		nav(1'b1);
		nav(1'b0);
	endtask
endmodule // jil_test_ctrl

/* File: testbench/jil_tap_top_tb_top.sv */
// jil_tap_top_tb_top: self-checking bench for the test access port
// assumes the default density (480 cells, 160 pins) and default opcodes
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value %s expected %0h seen %0h", nm, (e), (g)); end end
module jil_tap_top_tb_top;
	import jil_pkg::*;

	localparam logic [9:0]  OP_EXTEST   = 10'h00F;
	localparam logic [9:0]  OP_SAMPLE   = 10'h005;
	localparam logic [9:0]  OP_IDCODE   = 10'h006;
	localparam logic [9:0]  OP_USERCODE = 10'h007;
	localparam logic [9:0]  OP_HIGHZ    = 10'h00B;
	localparam logic [9:0]  OP_ISC_EN   = 10'h2CC;
	localparam logic [9:0]  OP_ISC_DIS  = 10'h201;
	localparam logic [9:0]  OP_ISC_PROG = 10'h2F4;
	localparam logic [9:0]  OP_ISC_READ = 10'h205;
	localparam logic [31:0] ID_EXP      = {4'h1, 16'h5A30, 11'h2A5, ID_FIXED_LSB};
	localparam logic [31:0] UCODE       = 32'hC0DE5EED;

	typedef struct {
		logic [9:0]  op;
		int          n;
		logic [31:0] din;
		logic [31:0] dexp;
		logic        sa;
		logic        sb;
	} jil_row_t;

	jil_row_t rows [5] = '{
		'{OP_IDCODE, 32, 32'h0, ID_EXP, 1'b0, 1'b0},
		'{OP_USERCODE, 32, 32'h0, UCODE, 1'b0, 1'b0},
		'{OP_CLAMP, 8, 32'hA5, 32'h4A, 1'b0, 1'b0},
		'{OP_USER_A, 8, 32'h3C, 32'h79, 1'b1, 1'b0},
		'{OP_USER_B, 8, 32'h3C, 32'h78, 1'b0, 1'b1}};

	logic         clk_i;
	logic         rst_i;
	logic         tck, tms, tdi, tdo, tdo_oe;
	logic         user_sel_a, user_sel_b, user_capture, user_shift, user_update, user_tdi, uc_r;
	logic         isc_active, isc_wr, isc_rd, pin_keep;
	logic [9:0]   isc_op;
	logic [15:0]  isc_wdata;
	logic [15:0]  wdata_seen;
	logic [159:0] pad_o, pad_oe, pad_in, core_out, core_in;
	int           n_fail, n_compared, n_wr, n_rd, n_upd;

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	jil_test_ctrl ctl (.clk_i(clk_i), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));

	jil_tap_top DUT (
		.clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
		.usercode_i(UCODE), .user_sel_a_o(user_sel_a), .user_sel_b_o(user_sel_b),
		.user_capture_o(user_capture), .user_shift_o(user_shift), .user_update_o(user_update),
		.user_tdi_o(user_tdi), .user_tdo_i(uc_r), .isc_active_o(isc_active), .isc_op_o(isc_op),
		.isc_wr_o(isc_wr), .isc_rd_o(isc_rd), .isc_wdata_o(isc_wdata), .isc_rdata_i(16'h5AC3),
		.pin_keep_o(pin_keep), .core_out_i(core_out), .core_oe_i('0), .core_in_o(core_in), .pad_i(pad_in),
		.pad_o(pad_o), .pad_oe_o(pad_oe));

	////////////////////////////////////////
	// user chain: one stage that captures the chain a select
	always @(posedge clk_i) begin
		if (user_capture === 1'b1)
			uc_r <= user_sel_a;
		else if (user_shift === 1'b1)
			uc_r <= user_tdi;
		if (isc_wr === 1'b1) begin
			n_wr++;
			wdata_seen = isc_wdata;
		end
		if (isc_rd === 1'b1)
			n_rd++;
		if (user_update === 1'b1)
			n_upd++;
	end

	task automatic load_ir(input logic [9:0] op);
		logic [511:0] d;
		ctl.scan(1'b1, 10, {502'h0, op}, d);
		`CHK("ir capture", IR_CAPTURE_VAL, d[9:0])
	endtask

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////
	initial begin
		logic [511:0] d;
		rst_i = 1'b1;
		uc_r = 1'b0;
		n_fail = 0;
		n_compared = 0;
		n_wr = 0;
		n_rd = 0;
		n_upd = 0;
		pad_in = 160'h1;
		core_out = 160'h2;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (3) @(negedge clk_i);
		ctl.nav(1'b0);
		foreach (rows[i]) begin
			load_ir(rows[i].op);
			`CHK("chain a select", rows[i].sa, user_sel_a)
			`CHK("chain b select", rows[i].sb, user_sel_b)
			ctl.scan(1'b0, rows[i].n, {480'h0, rows[i].din}, d);
			`CHK("data out", rows[i].dexp, d[31:0])
		end
		`CHK("user updates", 2, n_upd)
		load_ir(OP_SAMPLE);
		ctl.scan(1'b0, 496, 512'hFFFF, d);
		`CHK("chain length", 16'hFFFF, d[495:480])
		`CHK("sample capture", 5'h11, d[4:0])
		load_ir(OP_EXTEST);
		ctl.scan(1'b0, 480, 512'h6, d);
		`CHK("extest value", 160'h1, pad_o)
		`CHK("extest enable", 160'h1, pad_oe)
		load_ir(OP_CLAMP);
		`CHK("clamp enable", 160'h1, pad_oe)
		`CHK("clamp keep", 1'b1, pin_keep)
		`CHK("core in", 160'h1, core_in)
		load_ir(OP_HIGHZ);
		`CHK("highz enable", 160'h0, pad_oe)
		`CHK("highz keep", 1'b1, pin_keep)
		`CHK("highz value", 160'h2, pad_o)
		load_ir(OP_ISC_EN);
		`CHK("isc active", 1'b1, isc_active)
		load_ir(OP_ISC_PROG);
		ctl.scan(1'b0, 16, 512'hC3A5, d);
		`CHK("isc writes", 1, n_wr)
		`CHK("isc write data", 16'hC3A5, wdata_seen)
		load_ir(OP_ISC_READ);
		`CHK("isc op", OP_ISC_READ, isc_op)
		ctl.scan(1'b0, 16, 512'h0, d);
		`CHK("isc read back", 16'h5AC3, d[15:0])
		`CHK("isc reads", 1, n_rd)
		load_ir(OP_ISC_DIS);
		`CHK("isc exit", 1'b0, isc_active)
		load_ir(OP_USERCODE);
		// walk into update-dr so the five-ones walk leaves it with tms high
		ctl.nav(1'b1);
		ctl.nav(1'b0);
		ctl.nav(1'b1);
		ctl.nav(1'b1);
		ctl.to_reset();
		ctl.scan(1'b0, 32, 512'h0, d);
		`CHK("id after tms reset", ID_EXP, d[31:0])
		load_ir(OP_USERCODE);
		rst_i = 1'b1;
		repeat (3) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (3) @(negedge clk_i);
		ctl.nav(1'b0);
		ctl.scan(1'b0, 32, 512'h0, d);
		`CHK("id after reset", ID_EXP, d[31:0])
		`CHK("tdo enable in shift", 0, ctl.oe_bad)
		`CHK("tdo enable idle", 1'b0, tdo_oe)
		close_out();
	end

	// about 1470 test clock periods of 320 ns are needed; allow some four times that
	initial begin
		#2_000_000;
		n_fail++;
		close_out();
	end
endmodule // jil_tap_top_tb_top
